/* File: pkg/ais_pkg.sv */
// Purpose: Shared constants and types of the instruction subset core.
// Assumes: 14-bit instruction words and 8-bit data.
// Notes: Register offsets are byte addresses on the Avalon-MM slave.
package ais_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int BUS_AW = 5;
  localparam int BUS_DW = 32;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam int OPC5_LSB = 9;
  localparam int OPC6_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam logic [4:0] OPC_ADD_LIT = 5'h1F;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [5:0] OPC_AND_FILE = 6'h05;
  localparam logic [5:0] OPC_ADD_FILE = 6'h07;
  localparam logic [5:0] OPC_COMP_FILE = 6'h09;
  localparam logic [5:0] OPC_DEC_FILE = 6'h03;
  localparam logic [INSTR_W-1:0] CODE_CLR_ACCUM = 14'h0103;
  localparam logic [INSTR_W-1:0] CODE_CLR_WDOG = 14'h0064;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [BUS_AW-1:0] REG_CTRL = 5'h00;
  localparam logic [BUS_AW-1:0] REG_ACCUM = 5'h04;
  localparam logic [BUS_AW-1:0] REG_STATUS = 5'h08;
  localparam logic [BUS_AW-1:0] REG_WDOG = 5'h0C;
  localparam logic [BUS_AW-1:0] REG_COUNT = 5'h10;
  localparam int CTRL_EXEC_BIT = 0;
  localparam int CTRL_WDOG_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_UNSUP_BIT = 5;
  localparam int WDOG_PRE_LSB = 8;
  localparam int COUNT_W = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AIS_OP_NONE, AIS_OP_ADD, AIS_OP_AND, AIS_OP_COMP, AIS_OP_DEC, AIS_OP_CLR, AIS_OP_WDOG
  } ais_op_e;

  typedef struct packed {
    logic timeoutN;
    logic powerdownN;
    logic zero;
    logic digitCarry;
    logic carry;
  } ais_flags_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic carry;
    logic digitCarry;
    logic zero;
    logic updCarry;
    logic updZero;
  } ais_result_s;

endpackage : ais_pkg

/* File: src/ais_alu.sv */
// Purpose: Combinational arithmetic and logic for the instruction subset.
// Assumes: Operand is already muxed between literal and file value.
// Notes: Zero is always computed; updZero/updCarry say which flags move.
`timescale 1ns/1ps
module ais_alu (
  input wire ais_pkg::ais_op_e op, // decoded operation
  input wire logic [ais_pkg::DATA_W-1:0] accum, // working register
  input wire logic [ais_pkg::DATA_W-1:0] operand, // literal or file value
  output ais_pkg::ais_result_s res // result and flag updates
);
  import ais_pkg::*;

  logic [DATA_W:0] sum;
  logic [NIB_W:0] nibSum;

  assign sum = {1'b0, accum} + {1'b0, operand};
  assign nibSum = {1'b0, accum[NIB_W-1:0]} + {1'b0, operand[NIB_W-1:0]};

  always_comb begin
    res = '0;
    unique case (op)
      AIS_OP_ADD: begin
        res.data = sum[DATA_W-1:0];
        res.carry = sum[DATA_W];
        res.digitCarry = nibSum[NIB_W];
        res.updCarry = 1'b1;
        res.updZero = 1'b1;
      end
      AIS_OP_AND: begin
        res.data = accum & operand;
        res.updZero = 1'b1;
      end
      AIS_OP_COMP: begin
        res.data = ~operand;
        res.updZero = 1'b1;
      end
      AIS_OP_DEC: begin
        res.data = operand - DATA_W'(1);
        res.updZero = 1'b1;
      end
      AIS_OP_CLR: begin
        res.data = '0;
        res.updZero = 1'b1;
      end
      default: begin
        res.updZero = 1'b0;
      end
    endcase
    res.zero = (res.data == '0);
  end

endmodule : ais_alu

/* File: src/ais_watchdog.sv */
// Purpose: Watchdog counter with a free-running prescaler.
// Assumes: One prescaler wrap advances the counter by one.
// Notes: Clear wins over counting and over the expiry pulse.
`timescale 1ns/1ps
module ais_watchdog #(
  parameter int PRE_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic core_clk, // core clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic enable, // counting allowed
  input wire logic clear, // zero counter and prescaler
  output logic [CNT_W-1:0] count, // watchdog counter
  output logic [PRE_W-1:0] prescale, // prescaler
  output logic expired // one-cycle pulse on counter wrap
);

  wire preWrap = &prescale;
  wire cntWrap = &count;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      prescale <= '0;
      expired <= 1'b0;
    end else if (clear) begin
      count <= '0;
      prescale <= '0;
      expired <= 1'b0;
    end else if (enable) begin
      prescale <= prescale + PRE_W'(1);
      count <= preWrap ? count + CNT_W'(1) : count;
      expired <= preWrap & cntWrap;
    end else begin
      expired <= 1'b0;
    end
  end

endmodule : ais_watchdog

/* File: src/ais_core.sv */
// Purpose: Decode and execute a subset of a 14-bit instruction set.
// Assumes: The register file answers fileRdData combinationally from fileAddr.
// Notes: Two-stage flow, one instruction per cycle, with write forwarding.
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module ais_core #(
  parameter int WDOG_PRE_W = 8,
  parameter int WDOG_CNT_W = 8
) (
  input wire logic core_clk, // core clock, 100 MHz
  input wire logic nrst, // asynchronous reset, active low
  input wire logic instrValid, // fetch presents a word this cycle
  input wire logic [ais_pkg::INSTR_W-1:0] instrWord, // fetched word
  input wire logic [ais_pkg::DATA_W-1:0] fileRdData, // file value at fileAddr
  output logic [ais_pkg::FADDR_W-1:0] fileAddr, // file read address
  output logic fileWrEn, // file write strobe
  output logic [ais_pkg::FADDR_W-1:0] fileWrAddr, // file write address
  output logic [ais_pkg::DATA_W-1:0] fileWrData, // file write data
  output logic wdtExpired, // watchdog expiry pulse
  input wire logic [ais_pkg::BUS_AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [ais_pkg::BUS_DW-1:0] avs_writedata, // write data
  output logic [ais_pkg::BUS_DW-1:0] avs_readdata, // read data
  output logic avs_waitrequest // high until the access completes
);
  import ais_pkg::*;

  if (WDOG_PRE_W < 1 || WDOG_PRE_W > 8 || WDOG_CNT_W < 1 || WDOG_CNT_W > 8) begin : g_chk
    $error("Watchdog widths must lie between 1 and 8.");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [INSTR_W-1:0] instr_r;
  logic instrVal_r;
  logic [DATA_W-1:0] accum_r;
  logic [DATA_W-1:0] accum_nxt;
  ais_flags_s flags_r;
  ais_flags_s flags_nxt;
  logic unsup_r;
  logic unsup_nxt;
  logic [1:0] ctrl_r;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [BUS_DW-1:0] rdData_nxt;
  logic [WDOG_CNT_W-1:0] wdogCount;
  logic [WDOG_PRE_W-1:0] wdogPre;
  logic wdogExpired;
  ais_result_s aluRes;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [4:0] opc5 = instr_r[INSTR_W-1:OPC5_LSB];
  wire [5:0] opc6 = instr_r[INSTR_W-1:OPC6_LSB];
  wire [FADDR_W-1:0] instrFile = instr_r[FADDR_W-1:0];
  wire [DATA_W-1:0] instrLit = instr_r[DATA_W-1:0];

  wire isAddLit = (opc5 == OPC_ADD_LIT);
  wire isAndLit = (opc6 == OPC_AND_LIT);
  wire isAndFile = (opc6 == OPC_AND_FILE);
  wire isAddFile = (opc6 == OPC_ADD_FILE);
  wire isComp = (opc6 == OPC_COMP_FILE);
  wire isDec = (opc6 == OPC_DEC_FILE);
  wire isClrAccum = (instr_r == CODE_CLR_ACCUM);
  wire isClrWdog = (instr_r == CODE_CLR_WDOG);

  wire isKnown = isAddLit | isAndLit | isAndFile | isAddFile | isComp | isDec |
                 isClrAccum | isClrWdog;
  wire exec = instrVal_r & isKnown;
  wire execUnsup = instrVal_r & ~isKnown;
  wire srcLit = isAddLit | isAndLit;
  wire fileForm = isAndFile | isAddFile | isComp | isDec;
  wire toFile = fileForm & instr_r[DEST_BIT];

  ais_op_e decOp;
  assign decOp = !exec ? AIS_OP_NONE :
                 (isAddLit | isAddFile) ? AIS_OP_ADD :
                 (isAndLit | isAndFile) ? AIS_OP_AND :
                 isComp ? AIS_OP_COMP :
                 isDec ? AIS_OP_DEC :
                 isClrAccum ? AIS_OP_CLR : AIS_OP_WDOG;

  // A result written last cycle is not yet in the register file, so forward it.
  wire fwdHit = fileWrEn & (fileWrAddr == instrFile);
  wire [DATA_W-1:0] fileVal = fwdHit ? fileWrData : fileRdData;
  wire [DATA_W-1:0] operand = srcLit ? instrLit : fileVal;

  wire writesResult = exec & (decOp != AIS_OP_WDOG);
  wire accumLoad = writesResult & ~toFile;
  wire fileStore = writesResult & toFile;
  wire wdogClear = exec & isClrWdog;

  ais_alu u_alu (
    .op(decOp),
    .accum(accum_r),
    .operand(operand),
    .res(aluRes)
  );

  ais_watchdog #(
    .PRE_W(WDOG_PRE_W),
    .CNT_W(WDOG_CNT_W)
  ) u_wdog (
    .core_clk(core_clk),
    .nrst(nrst),
    .enable(ctrl_r[CTRL_WDOG_BIT]),
    .clear(wdogClear),
    .count(wdogCount),
    .prescale(wdogPre),
    .expired(wdogExpired)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire busReq = avs_read | avs_write;
  wire busTake = busReq & avs_waitrequest;
  wire busDone = busReq & ~avs_waitrequest;
  wire hitCtrl = (avs_address == REG_CTRL);
  wire hitAccum = (avs_address == REG_ACCUM);
  wire hitStatus = (avs_address == REG_STATUS);
  wire hitWdog = (avs_address == REG_WDOG);
  wire hitCount = (avs_address == REG_COUNT);
  wire swWrite = busDone & avs_write;
  wire wrCtrl = swWrite & hitCtrl;
  wire wrAccum = swWrite & hitAccum;
  wire wrStatus = swWrite & hitStatus;
  wire wrCount = swWrite & hitCount;

  wire [BUS_DW-1:0] statusWord = (BUS_DW'(flags_r.carry) << ST_C_BIT) |
                                 (BUS_DW'(flags_r.digitCarry) << ST_DC_BIT) |
                                 (BUS_DW'(flags_r.zero) << ST_Z_BIT) |
                                 (BUS_DW'(flags_r.powerdownN) << ST_PD_BIT) |
                                 (BUS_DW'(flags_r.timeoutN) << ST_TO_BIT) |
                                 (BUS_DW'(unsup_r) << ST_UNSUP_BIT);
  wire [BUS_DW-1:0] wdogWord = BUS_DW'(wdogCount) | (BUS_DW'(wdogPre) << WDOG_PRE_LSB);

  assign rdData_nxt = hitCtrl ? BUS_DW'(ctrl_r) :
                      hitAccum ? BUS_DW'(accum_r) :
                      hitStatus ? statusWord :
                      hitWdog ? wdogWord :
                      hitCount ? BUS_DW'(count_r) : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Execution takes priority over a software write in the same cycle.
  assign accum_nxt = accumLoad ? aluRes.data :
                     wrAccum ? avs_writedata[DATA_W-1:0] : accum_r;

  always_comb begin
    flags_nxt = flags_r;
    if (wrStatus) begin
      flags_nxt.carry = avs_writedata[ST_C_BIT];
      flags_nxt.digitCarry = avs_writedata[ST_DC_BIT];
      flags_nxt.zero = avs_writedata[ST_Z_BIT];
    end
    if (aluRes.updZero) begin
      flags_nxt.zero = aluRes.zero;
    end
    if (aluRes.updCarry) begin
      flags_nxt.carry = aluRes.carry;
      flags_nxt.digitCarry = aluRes.digitCarry;
    end
    if (wdogExpired) begin
      flags_nxt.timeoutN = 1'b0;
    end
    if (wdogClear) begin
      flags_nxt.timeoutN = 1'b1;
      flags_nxt.powerdownN = 1'b1;
    end
  end

  // A new unsupported word wins over a write-one-to-clear in the same cycle.
  assign unsup_nxt = execUnsup | (unsup_r & ~(wrStatus & avs_writedata[ST_UNSUP_BIT]));
  assign count_nxt = exec ? count_r + COUNT_W'(1) :
                     wrCount ? avs_writedata[COUNT_W-1:0] : count_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      instr_r <= '0;
      instrVal_r <= 1'b0;
      fileAddr <= '0;
    end else begin
      instr_r <= instrWord;
      instrVal_r <= instrValid & ctrl_r[CTRL_EXEC_BIT];
      fileAddr <= instrWord[FADDR_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      accum_r <= '0;
      flags_r <= '{timeoutN: 1'b1, powerdownN: 1'b1, default: 1'b0};
      unsup_r <= 1'b0;
      count_r <= '0;
      wdtExpired <= 1'b0;
    end else begin
      accum_r <= accum_nxt;
      flags_r <= flags_nxt;
      unsup_r <= unsup_nxt;
      count_r <= count_nxt;
      wdtExpired <= wdogExpired;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fileWrEn <= 1'b0;
      fileWrAddr <= '0;
      fileWrData <= '0;
    end else begin
      fileWrEn <= fileStore;
      fileWrAddr <= instrFile;
      fileWrData <= aluRes.data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      ctrl_r <= wrCtrl ? avs_writedata[1:0] : ctrl_r;
      avs_waitrequest <= ~busTake;
      avs_readdata <= busTake ? rdData_nxt : avs_readdata;
    end
  end

endmodule : ais_core

/* File: testbench/ais_core_properties.sv */
// Purpose: Concurrent checks on the ports of the instruction subset core.
// Assumes: Execution enabled; no same-address forwarding ahead of complement, decrement or AND.
// Notes: Bound to every instance of the core.
`timescale 1ns/1ps
module ais_core_properties #(
  parameter int WDOG_PRE_W = 8,
  parameter int WDOG_CNT_W = 8
) (
  input wire logic core_clk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic instrValid, // word offered
  input wire logic [ais_pkg::INSTR_W-1:0] instrWord, // fetched word
  input wire logic [ais_pkg::DATA_W-1:0] fileRdData, // file read data
  input wire logic [ais_pkg::FADDR_W-1:0] fileAddr, // file read address
  input wire logic fileWrEn, // file write strobe
  input wire logic [ais_pkg::FADDR_W-1:0] fileWrAddr, // file write address
  input wire logic [ais_pkg::DATA_W-1:0] fileWrData, // file write data
  input wire logic wdtExpired // expiry pulse
);
  import ais_pkg::*;
  // ----
  // Helpers
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire [5:0] opc = instrWord[13:8];
  wire toFile = instrValid && instrWord[7] && instrWord[13:12] == 2'h0;
  wire toAcc = instrValid && !instrWord[7] && instrWord[13:12] == 2'h0;
  wire noFile = instrValid && (instrWord[13:12] == 2'h3 || instrWord == CODE_CLR_ACCUM);
  // ----
  // Assertions
  // ----
  a_addr_follows: assert property (instrValid |=> fileAddr == $past(instrWord[6:0]))
    else $error("file address does not follow the word");
  a_comp_write: assert property (toFile && opc == OPC_COMP_FILE ##1 1'b1 |=> fileWrEn
    && fileWrData == ~$past(fileRdData) && fileWrAddr == $past(fileAddr))
    else $error("complement write wrong");
  a_dec_write: assert property (toFile && opc == OPC_DEC_FILE ##1 1'b1 |=> fileWrEn
    && fileWrData == $past(fileRdData) - 8'h01 && fileWrAddr == $past(fileAddr))
    else $error("decrement write wrong");
  a_and_subset: assert property (toFile && opc == OPC_AND_FILE ##1 1'b1 |=> fileWrEn
    && (fileWrData & ~$past(fileRdData)) == 8'h00 && fileWrAddr == $past(fileAddr))
    else $error("and write sets bits absent from the file value");
  a_add_dest: assert property (toFile && opc == OPC_ADD_FILE ##1 1'b1 |=> fileWrEn
    && fileWrAddr == $past(fileAddr)) else $error("add result not written back");
  a_acc_dest: assert property (toAcc ##1 1'b1 |=> !fileWrEn)
    else $error("file written for accumulator destination");
  a_lit_quiet: assert property (noFile ##1 1'b1 |=> !fileWrEn)
    else $error("file written by an accumulator only operation");
  // An expiry already in flight may still show two cycles after the clear lands, and with
  // the narrowest watchdog a fresh expiry can follow five cycles later, hence the window.
  a_wdog_quiet: assert property (instrValid && instrWord == CODE_CLR_WDOG |=> ##2 !wdtExpired [*4])
    else $error("expiry soon after watchdog clear");
endmodule : ais_core_properties

bind ais_core ais_core_properties #(.WDOG_PRE_W(WDOG_PRE_W), .WDOG_CNT_W(WDOG_CNT_W)) u_props (
  .core_clk(core_clk), .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord),
  .fileRdData(fileRdData), .fileAddr(fileAddr), .fileWrEn(fileWrEn),
  .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .wdtExpired(wdtExpired)
);

/* File: testbench/ais_regfile_model.sv */
// Purpose: Register file standing behind the core's file port.
// Assumes: Reads are combinational, writes land on the clock edge.
// Notes: The bench preloads and inspects mem directly.
`timescale 1ns/1ps
module ais_regfile_model (
  input wire logic core_clk, // core clock
  input wire logic [ais_pkg::FADDR_W-1:0] rdAddr, // read address
  output logic [ais_pkg::DATA_W-1:0] rdData, // read data
  input wire logic wrEn, // write strobe
  input wire logic [ais_pkg::FADDR_W-1:0] wrAddr, // write address
  input wire logic [ais_pkg::DATA_W-1:0] wrData // write data
);
  import ais_pkg::*;
  logic [DATA_W-1:0] mem [128];
  assign rdData = mem[rdAddr];
  always @(posedge core_clk) begin
    if (wrEn) mem[wrAddr] <= wrData;
  end
endmodule : ais_regfile_model

/* File: testbench/alu_instruction_subset_bench.sv */
// Purpose: Self-checking bench of the instruction subset core.
// Assumes: Watchdog widths of 2 make expiry arrive within 16 cycles.
// Notes: The watchdog is stopped after its test so status stays predictable.
`timescale 1ns/1ps
module alu_instruction_subset_bench;
  import ais_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic instrValid = 1'b0;
  logic [INSTR_W-1:0] instrWord = 14'h0000;
  logic [BUS_AW-1:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [BUS_DW-1:0] avs_writedata = 32'h0000_0000;
  wire [DATA_W-1:0] fileRdData, fileWrData;
  wire [FADDR_W-1:0] fileAddr, fileWrAddr;
  wire fileWrEn, wdtExpired, avs_waitrequest;
  wire [BUS_DW-1:0] avs_readdata;
  logic [DATA_W-1:0] bm [128];
  logic [DATA_W-1:0] acc = 8'h00;
  logic c = 1'b0, dc = 1'b0, z = 1'b0, tmo = 1'b1, pdn = 1'b1, uns = 1'b0;
  logic [BUS_DW-1:0] rd;
  int num_errors = 0, samples_checked = 0, n, cnt = 0;

  ais_core #(.WDOG_PRE_W(2), .WDOG_CNT_W(2)) dut (
    .core_clk(core_clk), .nrst(nrst), .instrValid(instrValid), .instrWord(instrWord),
    .fileRdData(fileRdData), .fileAddr(fileAddr), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .wdtExpired(wdtExpired),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  ais_regfile_model rf (.core_clk(core_clk), .rdAddr(fileAddr), .rdData(fileRdData),
    .wrEn(fileWrEn), .wrAddr(fileWrAddr), .wrData(fileWrData));

  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ----
  // Tasks
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Request is held until the edge that sees waitrequest low.
  task automatic bus(input logic wr, input logic [BUS_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [BUS_AW-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask : rchk
  task automatic step(input logic [INSTR_W-1:0] w);
    logic [DATA_W-1:0] op;
    logic [DATA_W-1:0] r;
    logic [8:0] s;
    logic [4:0] h;
    op = (w[13:12] == 2'h3) ? w[7:0] : bm[w[6:0]];
    s = {1'b0, acc} + {1'b0, op};
    h = {1'b0, acc[3:0]} + {1'b0, op[3:0]};
    r = op - 8'h01;
    // Words outside the subset only raise the sticky status bit.
    if (w[13:9] != OPC_ADD_LIT && w != CODE_CLR_ACCUM && w != CODE_CLR_WDOG &&
        !(w[13:8] inside {OPC_AND_LIT, OPC_AND_FILE, OPC_ADD_FILE, OPC_COMP_FILE,
        OPC_DEC_FILE})) begin
      uns = 1'b1;
      return;
    end
    cnt++;
    if (w == CODE_CLR_WDOG) begin
      tmo = 1'b1;
      pdn = 1'b1;
    end else begin
      if (w == CODE_CLR_ACCUM) r = 8'h00;
      else if (w[13:9] == OPC_ADD_LIT || w[13:8] == OPC_ADD_FILE) begin
        r = s[7:0];
        c = s[8];
        dc = h[4];
      end else if (w[13:8] == OPC_AND_LIT || w[13:8] == OPC_AND_FILE) r = acc & op;
      else if (w[13:8] == OPC_COMP_FILE) r = ~op;
      z = (r == 8'h00);
      if (w[13:12] == 2'h0 && w[7]) bm[w[6:0]] = r;
      else acc = r;
    end
  endtask : step
  task automatic issue(input logic [INSTR_W-1:0] w);
    @(posedge core_clk);
    instrValid <= 1'b1;
    instrWord <= w;
    step(w);
  endtask : issue
  task automatic settle();
    @(posedge core_clk);
    instrValid <= 1'b0;
    repeat (2) @(posedge core_clk);
    rchk(REG_ACCUM, {24'h00_0000, acc});
    rchk(REG_STATUS, {26'h000_0000, uns, tmo, pdn, z, dc, c});
    for (int i = 0; i < 128; i++) cmp(32'(rf.mem[i]), 32'(bm[i]));
    $display("test finished at %0t", $time);
  endtask : settle
  task automatic t1(input logic [INSTR_W-1:0] w);
    issue(w);
    settle();
  endtask : t1
  function automatic logic [13:0] fw(input logic [5:0] o, input logic d, input logic [6:0] f);
    return {o, d, f};
  endfunction : fw
  task automatic complete_run();
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ----
  // Sequence
  // ----
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 128; i++) bm[i] = 8'(i * 37 + 5);
    bm[10] = 8'h01;
    bm[11] = 8'h00;
    rf.mem = bm;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(REG_STATUS, 32'h0000_0018);
    rchk(REG_ACCUM, 32'h0000_0000);
    rchk(REG_CTRL, 32'h0000_0003);
    bus(1'b1, 5'h14, 32'h0000_00FF);
    rchk(5'h14, 32'h0000_0000);
    $display("reset values checked");
    n = 0;
    while (wdtExpired !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    cmp(32'(n < 200), 32'h0000_0001);
    rchk(REG_STATUS, 32'h0000_0008);
    // First clear lands while the watchdog still runs, well before its next expiry.
    t1(CODE_CLR_WDOG);
    bus(1'b1, REG_CTRL, 32'h0000_0001);
    t1(CODE_CLR_WDOG);
    rchk(REG_WDOG, 32'h0000_0000);
    bus(1'b1, REG_ACCUM, 32'h0000_009A);
    acc = 8'h9A;
    t1({OPC_ADD_LIT, 1'b0, 8'h7F});
    t1({OPC_AND_LIT, 8'h3D});
    t1(fw(OPC_AND_FILE, 1'b0, 7'h7F));
    t1(fw(OPC_AND_FILE, 1'b1, 7'h03));
    t1(fw(OPC_ADD_FILE, 1'b0, 7'h14));
    t1(fw(OPC_ADD_FILE, 1'b1, 7'h7F));
    t1(fw(OPC_COMP_FILE, 1'b0, 7'h1E));
    t1(fw(OPC_COMP_FILE, 1'b1, 7'h1F));
    t1(fw(OPC_DEC_FILE, 1'b0, 7'h0A));
    t1(fw(OPC_DEC_FILE, 1'b1, 7'h0B));
    t1(CODE_CLR_ACCUM);
    t1({OPC_ADD_LIT, 1'b1, 8'h00});
    issue({OPC_ADD_LIT, 1'b1, 8'h3C});
    issue(fw(OPC_ADD_FILE, 1'b1, 7'h28));
    issue(fw(OPC_ADD_FILE, 1'b1, 7'h28));
    issue(fw(OPC_DEC_FILE, 1'b0, 7'h29));
    issue(CODE_CLR_WDOG);
    settle();
    t1(14'h3835);
    bus(1'b1, REG_STATUS, {26'h000_0000, 1'b1, 2'b00, z, dc, c});
    uns = 1'b0;
    rchk(REG_STATUS, {26'h000_0000, uns, tmo, pdn, z, dc, c});
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    @(posedge core_clk);
    instrValid <= 1'b1;
    instrWord <= CODE_CLR_ACCUM;
    settle();
    rchk(REG_COUNT, 32'(cnt));
    complete_run();
  end
endmodule : alu_instruction_subset_bench
